// ### rtl/uart_rx_sampler.sv
// Receive shift register: samples the line at mid-bit, delivers bytes.
// Assumes the line comes from a pin; it is synchronised here.
`default_nettype none

module uart_rx_sampler (
  // Clock and reset
  input wire logic clock,
  input wire logic rstN,
  // Line and rate
  input wire logic tick16,
  input wire logic rxLine,
  // Received byte
  output logic valid,
  output logic [7:0] data
);
  typedef struct packed {
    logic [1:0] sync;
    uart_stat_pkg::frame_type st;
    logic [3:0] sub;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic valid;
  } state_type;

  state_type s_reg, s_next;
  logic lineNow;

  assign lineNow = s_reg.sync[1];

  // ***************************************************************
  // Frame capture
  // ***************************************************************
  // A start bit that is gone by mid-bit is treated as a glitch
  always_comb begin
    s_next = s_reg;
    s_next.sync = {s_reg.sync[0], rxLine};
    s_next.valid = 1'b0;
    case (s_reg.st)
      uart_stat_pkg::FR_IDLE: begin
        if (!lineNow) begin
          s_next.st = uart_stat_pkg::FR_START;
          s_next.sub = 4'h0;
          s_next.cnt = 4'h0;
        end
      end
      uart_stat_pkg::FR_START: begin
        if (tick16) begin
          s_next.sub = s_reg.sub + 4'h1;
          if (s_reg.sub == 4'(uart_stat_pkg::OVERSAMPLE / 2 - 1)) begin
            s_next.sub = 4'h0;
            s_next.st = lineNow ? uart_stat_pkg::FR_IDLE : uart_stat_pkg::FR_DATA;
          end
        end
      end
      uart_stat_pkg::FR_DATA: begin
        if (tick16) begin
          s_next.sub = s_reg.sub + 4'h1;
          if (s_reg.sub == 4'(uart_stat_pkg::OVERSAMPLE - 1)) begin
            s_next.shift = {lineNow, s_reg.shift[7:1]};
            s_next.cnt = s_reg.cnt + 4'h1;
            if (s_reg.cnt == 4'(uart_stat_pkg::DATA_BITS - 1)) begin
              s_next.st = uart_stat_pkg::FR_STOP;
            end
          end
        end
      end
      uart_stat_pkg::FR_STOP: begin
        if (tick16) begin
          s_next.sub = s_reg.sub + 4'h1;
          if (s_reg.sub == 4'(uart_stat_pkg::OVERSAMPLE - 1)) begin
            s_next.st = uart_stat_pkg::FR_IDLE;
            s_next.valid = lineNow;
          end
        end
      end
      default: s_next.st = uart_stat_pkg::FR_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_reg <= '0;
      s_reg.sync <= 2'h3;
    end else begin
      s_reg <= s_next;
    end
  end

  assign valid = s_reg.valid;
  assign data = s_reg.shift;
endmodule

`default_nettype wire

// ### rtl/uart_stat_pkg.sv
// Constants shared by the UART status/control block and its two helpers.
// Assumes a single 10 MHz clock and a 16-bit register port.
// Contract
// - Select 10: irq when buffer empties
// - Select 01: irq when last frame done
// - Select 00: irq per shifter load; 11 reserved
// - Plain line: invert set means idle low
// - Encoded line: invert set means idle high
// - Buffer full flag reads one when full
// - Shifter empty flag: all idle, nothing queued
// - Shifter empty reads zero while sending/queued
// - Receive select 11: irq at four characters
// - Receive select 10: irq at three characters
// - Receive select 0x: irq per received character
`default_nettype none

package uart_stat_pkg;
  // ***************************************************************
  // Register map (byte offsets) and widths
  // ***************************************************************
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_TXDATA = 8'h04;
  localparam logic [7:0] ADDR_RXDATA = 8'h08;
  localparam logic [7:0] ADDR_IRQSTAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQMASK = 8'h10;
  localparam logic [7:0] ADDR_MODE = 8'h14;

  // ***************************************************************
  // Status/control field positions
  // ***************************************************************
  localparam int B_TXISEL1 = 15;
  localparam int B_TXINV = 14;
  localparam int B_TXISEL0 = 13;
  localparam int B_BRK = 11;
  localparam int B_TXEN = 10;
  localparam int B_TXBF = 9;
  localparam int B_TX_SHIFTER_EMPTY = 8;
  localparam int B_RXISEL1 = 7;
  localparam int B_RXISEL0 = 6;
  localparam int B_INFRARED_ENCODE_ENABLE = 0;
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_BITS = 2;

  // ***************************************************************
  // Modes, counts and timing
  // ***************************************************************
  localparam logic [1:0] TXI_ANY = 2'h0;
  localparam logic [1:0] TXI_DONE = 2'h1;
  localparam logic [1:0] TXI_EMPTY = 2'h2;
  localparam logic [1:0] RXI_FULL = 2'h3;
  localparam logic [1:0] RXI_THREE = 2'h2;
  localparam int FIFO_DEPTH = 4;
  localparam int RX_THREE_LEVEL = 3;
  localparam int DATA_BITS = 8;
  localparam int BREAK_ZEROS = 12;
  localparam int OVERSAMPLE = 16;
  localparam int IR_PULSE = 3;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD = 9600;
  localparam int TICK_DIV = CLK_HZ / (BAUD * OVERSAMPLE);

  // Frame states, Gray along idle-start-data-stop
  typedef enum logic [1:0] {
    FR_IDLE = 2'h0,
    FR_START = 2'h1,
    FR_DATA = 2'h3,
    FR_STOP = 2'h2
  } frame_type;
endpackage

`default_nettype wire

// ### rtl/uart_status_irq.sv
// UART status/control: interrupt selection, line polarity, break, flags.
// Assumes a plain register port on the 10 MHz clock and a pin-level line.
`default_nettype none

module uart_status_irq #(
  parameter int DEPTH = uart_stat_pkg::FIFO_DEPTH,
  parameter int TICK_DIV = uart_stat_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Register port
  input wire logic [uart_stat_pkg::ADDR_W-1:0] addr,
  input wire logic [uart_stat_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [uart_stat_pkg::DATA_W-1:0] rdata,
  // Serial line
  input wire logic rxLine,
  output logic txLine,
  output logic txLineOe,
  // Interrupt
  output logic irq
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int DIV_W = $clog2(TICK_DIV + 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] ONE = CNT_W'(1);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
    logic [1:0] txisel;
    logic txinv;
    logic infrared_encode_enable;
    logic brk;
    logic brkRun;
    logic txen;
    logic [1:0] rxisel;
    logic [DEPTH-1:0][7:0] txBuf;
    logic [PTR_W-1:0] txWp;
    logic [PTR_W-1:0] txRp;
    logic [CNT_W-1:0] txCount;
    logic shStart;
    logic [DEPTH-1:0][7:0] rxBuf;
    logic [PTR_W-1:0] rxWp;
    logic [PTR_W-1:0] rxRp;
    logic [CNT_W-1:0] rxCount;
    logic [uart_stat_pkg::IRQ_BITS-1:0] irqStat;
    logic [uart_stat_pkg::IRQ_BITS-1:0] irqMask;
    logic [uart_stat_pkg::DATA_W-1:0] rdata;
    logic txLine;
    logic txOe;
    logic irq;
  } state_type;

  state_type r_reg, r_next;
  logic [1:0] rstPipe;
  logic rstN;
  logic shBit, shIr, shBusy, shDone, rxValid;
  logic [7:0] rxByte;
  logic txPush, txPop, rxPush, rxPop, tx_shifter_empty;
  logic [CNT_W-1:0] txAfter, rxAfter;
  logic [uart_stat_pkg::IRQ_BITS-1:0] ev;
  logic [uart_stat_pkg::DATA_W-1:0] statusWord;

  // ***************************************************************
  // Reset release and helpers
  // ***************************************************************
  // Release is synchronised so that no flop leaves reset on a split edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstN = rstPipe[1];

  // The read pointer has already moved on when the start strobe arrives
  uart_tx_shifter uart_tx_shifter_inst (
    .clock(clock),
    .rstN(rstN),
    .tick16(r_reg.tick),
    .abort(!r_reg.txen),
    .start(r_reg.shStart),
    .sendBreak(r_reg.brkRun),
    .data(r_reg.txBuf[r_reg.txRp - PTR_W'(1)]),
    .bitOut(shBit),
    .irPhase(shIr),
    .busy(shBusy),
    .done(shDone)
  );

  uart_rx_sampler uart_rx_sampler_inst (
    .clock(clock),
    .rstN(rstN),
    .tick16(r_reg.tick),
    .rxLine(rxLine),
    .valid(rxValid),
    .data(rxByte)
  );

  // ***************************************************************
  // Buffer movement and events
  // ***************************************************************
  // Loads are held off while a start is pending, so one byte per frame
  always_comb begin
    txPush = wr && addr == uart_stat_pkg::ADDR_TXDATA && r_reg.txen && r_reg.txCount != FULL;
    txPop = r_reg.txen && !shBusy && !r_reg.shStart && r_reg.txCount != '0;
    rxPush = rxValid && r_reg.rxCount != FULL;
    rxPop = rd && addr == uart_stat_pkg::ADDR_RXDATA && r_reg.rxCount != '0;
    txAfter = r_reg.txCount + (txPush ? ONE : '0) - (txPop ? ONE : '0);
    rxAfter = r_reg.rxCount + (rxPush ? ONE : '0) - (rxPop ? ONE : '0);
    tx_shifter_empty = r_reg.txCount == '0 && !shBusy && !r_reg.shStart;
    ev = '0;
    case (r_reg.txisel)
      uart_stat_pkg::TXI_ANY: ev[uart_stat_pkg::IRQ_TX] = txPop;
      uart_stat_pkg::TXI_EMPTY: ev[uart_stat_pkg::IRQ_TX] = txPop && txAfter == '0;
      uart_stat_pkg::TXI_DONE: ev[uart_stat_pkg::IRQ_TX] = shDone && tx_shifter_empty;
      default: ev[uart_stat_pkg::IRQ_TX] = 1'b0; // Reserved code raises nothing
    endcase
    case (r_reg.rxisel)
      uart_stat_pkg::RXI_FULL: ev[uart_stat_pkg::IRQ_RX] = rxPush && rxAfter == FULL;
      uart_stat_pkg::RXI_THREE: begin
        ev[uart_stat_pkg::IRQ_RX] = rxPush && rxAfter == CNT_W'(uart_stat_pkg::RX_THREE_LEVEL);
      end
      default: ev[uart_stat_pkg::IRQ_RX] = rxPush;
    endcase
    statusWord = '0;
    statusWord[uart_stat_pkg::B_TXISEL1] = r_reg.txisel[1];
    statusWord[uart_stat_pkg::B_TXINV] = r_reg.txinv;
    statusWord[uart_stat_pkg::B_TXISEL0] = r_reg.txisel[0];
    statusWord[uart_stat_pkg::B_BRK] = r_reg.brk;
    statusWord[uart_stat_pkg::B_TXEN] = r_reg.txen;
    statusWord[uart_stat_pkg::B_TXBF] = r_reg.txCount == FULL;
    statusWord[uart_stat_pkg::B_TX_SHIFTER_EMPTY] = tx_shifter_empty;
    statusWord[uart_stat_pkg::B_RXISEL1] = r_reg.rxisel[1];
    statusWord[uart_stat_pkg::B_RXISEL0] = r_reg.rxisel[0];
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    r_next = r_reg;
    // Bit-rate divider
    r_next.tick = 1'b0;
    r_next.div = r_reg.div + DIV_W'(1);
    if (r_reg.div == DIV_W'(TICK_DIV - 1)) begin
      r_next.div = '0;
      r_next.tick = 1'b1;
    end
    // Transmit buffer; a break frame also consumes the queued byte
    r_next.shStart = 1'b0;
    if (txPush) begin
      r_next.txBuf[r_reg.txWp] = wdata[7:0];
      r_next.txWp = r_reg.txWp + PTR_W'(1);
    end
    if (txPop) begin
      r_next.txRp = r_reg.txRp + PTR_W'(1);
      r_next.shStart = 1'b1;
      r_next.brkRun = r_reg.brk;
    end
    r_next.txCount = txAfter;
    // Break bit drops when the break frame ends
    if (shDone && r_reg.brkRun) begin
      r_next.brk = 1'b0;
      r_next.brkRun = 1'b0;
    end
    // Receive buffer; bytes that find it full are dropped
    if (rxPush) begin
      r_next.rxBuf[r_reg.rxWp] = rxByte;
      r_next.rxWp = r_reg.rxWp + PTR_W'(1);
    end
    if (rxPop) begin
      r_next.rxRp = r_reg.rxRp + PTR_W'(1);
    end
    r_next.rxCount = rxAfter;
    // Register writes; a software set of break wins over hardware clear
    if (wr) begin
      case (addr)
        uart_stat_pkg::ADDR_STATUS: begin
          r_next.txisel = {wdata[uart_stat_pkg::B_TXISEL1], wdata[uart_stat_pkg::B_TXISEL0]};
          r_next.txinv = wdata[uart_stat_pkg::B_TXINV];
          r_next.brk = wdata[uart_stat_pkg::B_BRK];
          r_next.txen = wdata[uart_stat_pkg::B_TXEN];
          r_next.rxisel = {wdata[uart_stat_pkg::B_RXISEL1], wdata[uart_stat_pkg::B_RXISEL0]};
        end
        uart_stat_pkg::ADDR_IRQMASK: r_next.irqMask = wdata[uart_stat_pkg::IRQ_BITS-1:0];
        uart_stat_pkg::ADDR_MODE: r_next.infrared_encode_enable = wdata[uart_stat_pkg::B_INFRARED_ENCODE_ENABLE];
        default: r_next.irqMask = r_reg.irqMask;
      endcase
    end
    // Disabled transmitter flushes its queue and abandons any frame
    if (!r_reg.txen) begin
      r_next.txCount = '0;
      r_next.txWp = '0;
      r_next.txRp = '0;
      r_next.shStart = 1'b0;
      r_next.brkRun = 1'b0;
    end
    // Sticky status: new events win over a same-cycle clear
    r_next.irqStat = r_reg.irqStat;
    if (wr && addr == uart_stat_pkg::ADDR_IRQSTAT) begin
      r_next.irqStat = r_reg.irqStat & ~wdata[uart_stat_pkg::IRQ_BITS-1:0];
    end
    r_next.irqStat = r_next.irqStat | ev;
    r_next.irq = |(r_next.irqStat & r_next.irqMask);
    // Read data, valid only in the cycle after the strobe
    r_next.rdata = '0;
    if (rd) begin
      case (addr)
        uart_stat_pkg::ADDR_STATUS: r_next.rdata = statusWord;
        uart_stat_pkg::ADDR_RXDATA: r_next.rdata = {8'h00, r_reg.rxBuf[r_reg.rxRp]};
        uart_stat_pkg::ADDR_IRQSTAT: r_next.rdata[uart_stat_pkg::IRQ_BITS-1:0] = r_reg.irqStat;
        uart_stat_pkg::ADDR_IRQMASK: r_next.rdata[uart_stat_pkg::IRQ_BITS-1:0] = r_reg.irqMask;
        uart_stat_pkg::ADDR_MODE: r_next.rdata[uart_stat_pkg::B_INFRARED_ENCODE_ENABLE] = r_reg.infrared_encode_enable;
        default: r_next.rdata = '0; // Unmapped reads return zero
      endcase
    end
    // Line encoding: pulse only in the first part of a zero bit
    if (r_reg.infrared_encode_enable) begin
      r_next.txLine = (!shBit && shIr) ^ r_reg.txinv;
    end else begin
      r_next.txLine = shBit ^ r_reg.txinv;
    end
    r_next.txOe = r_reg.txen;
    if (!r_reg.txen) begin
      r_next.txLine = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata = r_reg.rdata;
  assign txLine = r_reg.txLine;
  assign txLineOe = r_reg.txOe;
  assign irq = r_reg.irq;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstN);

  property p_txEmptyIrq;
    r_reg.txisel == uart_stat_pkg::TXI_EMPTY && txPop && txAfter == '0
      |=> r_reg.irqStat[uart_stat_pkg::IRQ_TX];
  endproperty
  a_txEmptyIrq: assert property (p_txEmptyIrq) else $error("empty-buffer irq missing");

  property p_txDoneIrq;
    r_reg.txisel == uart_stat_pkg::TXI_DONE && shDone && tx_shifter_empty
      |=> r_reg.irqStat[uart_stat_pkg::IRQ_TX];
  endproperty
  a_txDoneIrq: assert property (p_txDoneIrq) else $error("done irq missing");

  property p_txAnyIrq;
    r_reg.txisel == uart_stat_pkg::TXI_ANY && txPop |=> r_reg.irqStat[uart_stat_pkg::IRQ_TX];
  endproperty
  a_txAnyIrq: assert property (p_txAnyIrq) else $error("load irq missing");

  property p_plainIdle;
    r_reg.txen && !r_reg.infrared_encode_enable && shBit |=> txLine == !$past(r_reg.txinv);
  endproperty
  a_plainIdle: assert property (p_plainIdle) else $error("plain line level wrong");

  property p_irIdle;
    r_reg.txen && r_reg.infrared_encode_enable && shBit |=> txLine == $past(r_reg.txinv);
  endproperty
  a_irIdle: assert property (p_irIdle) else $error("encoded idle level wrong");

  property p_breakClear;
    shDone && r_reg.brkRun && !(wr && addr == uart_stat_pkg::ADDR_STATUS) |=> !r_reg.brk;
  endproperty
  a_breakClear: assert property (p_breakClear) else $error("break bit not cleared");

  property p_fullFlag;
    rd && addr == uart_stat_pkg::ADDR_STATUS
      |=> rdata[uart_stat_pkg::B_TXBF] == ($past(r_reg.txCount) == FULL);
  endproperty
  a_fullFlag: assert property (p_fullFlag) else $error("buffer full flag wrong");

  property p_emptyFlag;
    rd && addr == uart_stat_pkg::ADDR_STATUS
      |=> rdata[uart_stat_pkg::B_TX_SHIFTER_EMPTY] == $past(tx_shifter_empty);
  endproperty
  a_emptyFlag: assert property (p_emptyFlag) else $error("shifter empty flag wrong");

  property p_rxFour;
    r_reg.rxisel == uart_stat_pkg::RXI_FULL && rxPush && rxAfter == FULL
      |=> r_reg.irqStat[uart_stat_pkg::IRQ_RX];
  endproperty
  a_rxFour: assert property (p_rxFour) else $error("four-char irq missing");

  property p_rxThree;
    r_reg.rxisel == uart_stat_pkg::RXI_THREE && rxPush
      && rxAfter == CNT_W'(uart_stat_pkg::RX_THREE_LEVEL)
      |=> r_reg.irqStat[uart_stat_pkg::IRQ_RX];
  endproperty
  a_rxThree: assert property (p_rxThree) else $error("three-char irq missing");

  property p_rxAny;
    !r_reg.rxisel[1] && rxPush |=> r_reg.irqStat[uart_stat_pkg::IRQ_RX];
  endproperty
  a_rxAny: assert property (p_rxAny) else $error("receive irq missing");

  property p_disable;
    !r_reg.txen |=> !txLineOe && r_reg.txCount == '0 ##1 !shBusy;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not flush");

  c_breakDone: cover property (r_reg.brkRun && shDone);
  c_rxFull: cover property (rxPush && rxAfter == FULL);
  c_txFull: cover property (r_reg.txCount == FULL ##1 txPop);
endmodule

`default_nettype wire

// ### rtl/uart_tx_shifter.sv
// Transmit shift register: sends one data frame or one break frame.
// Assumes a 16x bit-rate enable pulse and a synchronous abort.
`default_nettype none

module uart_tx_shifter (
  // Clock and reset
  input wire logic clock,
  input wire logic rstN,
  // Control
  input wire logic tick16,
  input wire logic abort,
  input wire logic start,
  input wire logic sendBreak,
  input wire logic [7:0] data,
  // Line side
  output logic bitOut,
  output logic irPhase,
  output logic busy,
  output logic done
);
  typedef struct packed {
    uart_stat_pkg::frame_type st;
    logic [3:0] sub;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic brk;
    logic done;
  } state_type;

  state_type s_reg, s_next;

  // ***************************************************************
  // Frame sequencing
  // ***************************************************************
  // Break frames hold zero for thirteen bit times (start bit plus twelve) before the stop bit
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (abort) begin
      s_next.st = uart_stat_pkg::FR_IDLE;
      s_next.sub = 4'h0;
    end else if (s_reg.st == uart_stat_pkg::FR_IDLE) begin
      if (start) begin
        s_next.st = uart_stat_pkg::FR_START;
        s_next.sub = 4'h0;
        s_next.cnt = 4'h0;
        s_next.shift = data;
        s_next.brk = sendBreak;
      end
    end else if (tick16) begin
      s_next.sub = s_reg.sub + 4'h1;
      if (s_reg.sub == 4'(uart_stat_pkg::OVERSAMPLE - 1)) begin
        case (s_reg.st)
          uart_stat_pkg::FR_START: s_next.st = uart_stat_pkg::FR_DATA;
          uart_stat_pkg::FR_DATA: begin
            s_next.cnt = s_reg.cnt + 4'h1;
            s_next.shift = {1'b0, s_reg.shift[7:1]};
            if (s_reg.cnt == (s_reg.brk ? 4'(uart_stat_pkg::BREAK_ZEROS - 1)
                                        : 4'(uart_stat_pkg::DATA_BITS - 1))) begin
              s_next.st = uart_stat_pkg::FR_STOP;
            end
          end
          uart_stat_pkg::FR_STOP: begin
            s_next.st = uart_stat_pkg::FR_IDLE;
            s_next.done = 1'b1;
          end
          default: s_next.st = uart_stat_pkg::FR_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Raw line level, high when idle
  always_comb begin
    case (s_reg.st)
      uart_stat_pkg::FR_START: bitOut = 1'b0;
      uart_stat_pkg::FR_DATA: bitOut = s_reg.brk ? 1'b0 : s_reg.shift[0];
      default: bitOut = 1'b1;
    endcase
  end

  assign irPhase = s_reg.sub < 4'(uart_stat_pkg::IR_PULSE);
  assign busy = s_reg.st != uart_stat_pkg::FR_IDLE;
  assign done = s_reg.done;
endmodule

`default_nettype wire

// ### tb/uart_line_partner.sv
// Remote serial transceiver model: sends and receives 8N1 frames.
// Assumes LSB first, a line pulled high when released, bit time in clocks.
`default_nettype none

module uart_line_partner #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input wire logic clock,
  // Line
  input wire logic txLine,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Line timing and frames
  // ****************************************
  int lowRun = 0;
  int maxLow = 0;

  // Longest low stretch, so a break can be timed in bit periods
  always @(posedge clock) begin
    lowRun <= txLine ? 0 : lowRun + 1;
    if (lowRun > maxLow) maxLow <= lowRun;
  end

  initial rxLine = 1'b1;

  // One frame toward the block; the line rests high between frames
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      rxLine <= f[i];
      repeat (BIT_CLKS) @(posedge clock);
    end
  endtask

  // Bounded wait for a start bit, mid-bit sampling, stop bit checked
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (txLine !== 1'b0 && n < 40 * BIT_CLKS) begin
      @(posedge clock);
      n++;
    end
    ok = (n < 40 * BIT_CLKS);
    repeat (BIT_CLKS / 2) @(posedge clock);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CLKS) @(posedge clock);
      if (i < 8) b[i] = txLine;
      else ok = ok && (txLine === 1'b1);
    end
  endtask
endmodule

`default_nettype wire

// ### tb/uart_status_irq_tb.sv
// Self-checking bench for the UART status/control block.
// Assumes the package register map and a shortened bit clock.
`default_nettype none

module uart_status_irq_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Harness
  // ****************************************
  localparam int TDIV = 1;
  localparam int BITC = 16 * TDIV;
  localparam logic [7:0] ST = uart_stat_pkg::ADDR_STATUS;
  localparam logic [7:0] TX = uart_stat_pkg::ADDR_TXDATA;
  localparam logic [7:0] RX = uart_stat_pkg::ADDR_RXDATA;
  localparam logic [7:0] IS = uart_stat_pkg::ADDR_IRQSTAT;
  localparam logic [7:0] IM = uart_stat_pkg::ADDR_IRQMASK;
  localparam logic [7:0] MD = uart_stat_pkg::ADDR_MODE;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic rxLine, txLine, txLineOe, irq;
  int num_errors = 0;
  int compares = 0;

  uart_status_irq #(.TICK_DIV(TDIV)) uart_status_irq_inst (
    .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .rxLine(rxLine), .txLine(txLine), .txLineOe(txLineOe), .irq(irq));
  // Released pin is pulled high, as the far end sees it
  uart_line_partner #(.BIT_CLKS(BITC)) uart_line_partner_inst (
    .clock(clock), .txLine(txLineOe ? txLine : 1'b1), .rxLine(rxLine));

  initial forever #50 clock = ~clock;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bail();
    num_errors++;
    wrap_up();
  endtask

  // Bus tasks sync to the edge themselves; a gap cycle follows each strobe
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd_reg(a, v);
    chk(v, exp);
  endtask

  // Settle past the edge before looking at pins
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic expect_byte(input logic [7:0] exp);
    logic [7:0] b;
    logic ok;
    uart_line_partner_inst.get_byte(b, ok);
    if (ok !== 1'b1) bail();
    chk({8'h00, b}, {8'h00, exp});
  endtask

  // ****************************************
  // Scenarios (tx select codes never use the reserved 11)
  // ****************************************
  task automatic t_reset();
    rd_chk(ST, 16'h0100);
    chk(16'(txLineOe), 16'h0000);
    rd_chk(8'h20, 16'h0000);
  endtask

  task automatic t_tx_any();
    wr_reg(IM, 16'h0003);
    wr_reg(ST, 16'h0400);
    cyc(1);
    chk(16'(txLineOe), 16'h0001);
    wr_reg(TX, 16'h00A5);
    expect_byte(8'hA5);
    cyc(1);
    chk(16'(irq), 16'h0001);
    cyc(2 * BITC);
    rd_chk(ST, 16'h0500);
    rd_chk(IS, 16'h0001);
    wr_reg(IS, 16'h0003);
    cyc(1);
    chk(16'(irq), 16'h0000);
  endtask

  task automatic t_tx_done();
    wr_reg(ST, 16'h2400);
    wr_reg(TX, 16'h003C);
    // Look early, so the partner still catches the start bit
    cyc(1);
    chk(16'(irq), 16'h0000);
    rd_chk(ST, 16'h2400);
    expect_byte(8'h3C);
    cyc(2 * BITC);
    chk(16'(irq), 16'h0001);
  endtask

  task automatic t_tx_empty();
    wr_reg(ST, 16'h8400);
    wr_reg(TX, 16'h0011);
    wr_reg(TX, 16'h0022);
    wr_reg(TX, 16'h0033);
    wr_reg(IS, 16'h0003);
    expect_byte(8'h11);
    expect_byte(8'h22);
    cyc(1);
    chk(16'(irq), 16'h0000);
    expect_byte(8'h33);
    cyc(1);
    chk(16'(irq), 16'h0001);
  endtask

  task automatic t_full();
    wr_reg(ST, 16'h0400);
    for (int i = 0; i < 5; i++) wr_reg(TX, 16'h0040);
    rd_chk(ST, 16'h0600);
    wr_reg(ST, 16'h0000);
    cyc(1);
    chk(16'(txLineOe), 16'h0000);
    rd_chk(ST, 16'h0100);
  endtask

  task automatic t_break();
    logic [15:0] v;
    int n;
    wr_reg(ST, 16'h0C00);
    uart_line_partner_inst.maxLow = 0;
    wr_reg(TX, 16'h0000);
    n = 0;
    v = 16'h0800;
    while (v[11] === 1'b1 && n < 200) begin
      rd_reg(ST, v);
      n++;
    end
    if (n == 200) bail();
    chk(16'((uart_line_partner_inst.maxLow + BITC / 2) / BITC), 16'h000D);
  endtask

  task automatic idle_chk(input logic [7:0] a, input logic [15:0] d, input logic e);
    wr_reg(a, d);
    cyc(2);
    chk(16'(txLine), 16'(e));
  endtask

  // Every receive select code, each with its own fill level
  task automatic t_rx();
    logic [15:0] sel [4] = '{16'h04C0, 16'h0480, 16'h0440, 16'h0400};
    int thr [4] = '{4, 3, 1, 1};
    for (int m = 0; m < 4; m++) begin
      wr_reg(ST, sel[m]);
      wr_reg(IS, 16'h0003);
      for (int i = 1; i <= thr[m]; i++) begin
        cyc(1);
        chk(16'(irq), 16'h0000);
        uart_line_partner_inst.send_byte(8'(8'h60 + i));
        cyc(BITC);
      end
      chk(16'(irq), 16'h0001);
      for (int i = 1; i <= thr[m]; i++) rd_chk(RX, 16'(8'h60 + i));
    end
  endtask

  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_tx_any();
    t_tx_done();
    t_tx_empty();
    t_full();
    t_break();
    idle_chk(ST, 16'h4400, 1'b0);
    idle_chk(MD, 16'h0001, 1'b1);
    idle_chk(ST, 16'h0400, 1'b0);
    idle_chk(MD, 16'h0000, 1'b1);
    t_rx();
    wrap_up();
  end
endmodule

`default_nettype wire
